// ---- pkg/urxfc_pkg.sv ----
// Constants and types shared by the receive path and flow-control logic.
package urxfc_pkg;
  localparam int FIFO_DEPTH = 16;
  localparam int DATA_W = 8;
  localparam int ERR_W = 3;
  localparam int ENTRY_W = DATA_W + ERR_W;
  localparam int PTR_W = 4;
  localparam int CNT_W = 5;
  localparam int BUF_DEPTH = 2;
  localparam logic [1:0] XOFF_DELAY_CHARS = 2'h2;
  localparam logic [7:0] CHAR_RESET = 8'h00;
  localparam logic [1:0] SEL_XON1 = 2'h0;
  localparam logic [1:0] SEL_XON2 = 2'h1;
  localparam logic [1:0] SEL_XOFF1 = 2'h2;
  localparam logic [1:0] SEL_XOFF2 = 2'h3;
  localparam logic [CNT_W-1:0] CNT_FULL = 5'h10;
  localparam logic [CNT_W-1:0] CNT_ONE = 5'h01;
  localparam logic [3:0][CNT_W-1:0] TRIG_LVL = {5'h0e, 5'h08, 5'h04, 5'h01};
  localparam logic [3:0][CNT_W-1:0] TRIG_HI = {5'h10, 5'h0e, 5'h08, 5'h04};
  localparam logic [3:0][CNT_W-1:0] TRIG_LO = {5'h08, 5'h04, 5'h01, 5'h00};
  localparam logic [3:0][DATA_W-1:0] WORD_MASK = {8'hff, 8'h7f, 8'h3f, 8'h1f};

  typedef enum logic [2:0] {
    URXFC_PAIR_IDLE = 3'b001,
    URXFC_PAIR_XON1 = 3'b010,
    URXFC_PAIR_XOFF1 = 3'b100
  } urxfc_pair_t;
endpackage

// ---- src/urxfc_buf.sv ----
// Two-entry elastic buffer between the receiver and the receive FIFO.
`timescale 1ns/1ps
module urxfc_buf #(
  parameter int W = 11
) (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic ce_in,
  input wire logic in_valid_in,
  input wire logic [W-1:0] in_data_in,
  output logic in_ready_out,
  output logic out_valid_out,
  output logic [W-1:0] out_data_out,
  input wire logic out_ready_in
);
  import urxfc_pkg::*;

  typedef struct packed {
    logic [1:0][W-1:0] slot;
    logic [1:0] cnt;
  } urxfc_buf_t;

  urxfc_buf_t s_q;
  urxfc_buf_t s_d;
  logic push;
  logic pop;

  generate
    if (W < 1)
    begin : g_bad_width
      $error("Buffer width must be positive.");
    end
  endgenerate

  // Ready is a registered not-full, so a word offered while full simply waits upstream.
  assign in_ready_out = (s_q.cnt != 2'h2);
  assign out_valid_out = (s_q.cnt != 2'h0);
  assign out_data_out = s_q.slot[0];
  assign push = in_valid_in && in_ready_out;
  assign pop = out_valid_out && out_ready_in;

  always_comb
  begin
    s_d = s_q;
    if (pop)
    begin
      s_d.slot[0] = s_q.slot[1];
    end
    if (push)
    begin
      if (s_q.cnt == 2'h0 || (s_q.cnt == 2'h1 && pop))
      begin
        s_d.slot[0] = in_data_in;
      end
      else
      begin
        s_d.slot[1] = in_data_in;
      end
    end
    s_d.cnt = s_q.cnt + {1'b0, push} - {1'b0, pop};
  end

  always_ff @(posedge clk_in)
  begin
    if (!rstn_in)
    begin
      s_q <= '0;
    end
    else if (ce_in)
    begin
      s_q <= s_d;
    end
  end
endmodule // urxfc_buf

// ---- src/urxfc_top.sv ----
// Receive FIFO with hardware and software flow control.
// Summary of operation
// - Received bytes sit in a 16-entry FIFO, 8 data plus 3 error bits.
// - With the FIFO enabled, the holding register shows the oldest byte.
// - Reading the holding register advances the FIFO; error tags follow at once.
// - Auto RTS needs its enable and the host asserting RTS, in either order.
// - RTS going high sets status bit 5 and interrupts, if enabled.
// - Interrupt at the trigger; RTS drops only at the next higher table level.
// - RTS returns once the FIFO drains to the next lower table level.
// - While RTS is dropped, bytes keep being stored until the FIFO is full.
// - Auto CTS enable lets the CTS input gate the transmitter.
// - CTS deassertion sets status bit 5 and interrupts, if enabled.
// - On CTS loss the transmitter stops after the current character.
// - A received Xoff match halts the transmitter after its current character.
// - Xoff match with its enable sets the Xoff flag and interrupts.
// - After Xoff, an Xon match resumes transmission and clears status bit 4.
// - Reset zeroes the four flow characters; the host may rewrite them.
// - Double-character mode matches two consecutive bytes against each pair.
// - Bytes consumed as Xon or Xoff are not stored in the FIFO, except Xoff2 matches in special mode.
// - Auto Xoff is sent two character times after crossing the trigger.
// - Xon is sent when the fill falls to the next lower table level.
// - Special mode stores Xoff2 matches and sets status bit 4.
// - All character compares use only the programmed word length.
`timescale 1ns/1ps
module urxfc_top #(
  parameter int DEPTH = urxfc_pkg::FIFO_DEPTH
) (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic ce_in,
  input wire logic rx_valid_in,
  input wire logic [urxfc_pkg::DATA_W-1:0] rx_data_in,
  input wire logic [urxfc_pkg::ERR_W-1:0] rx_err_in,
  output logic rx_ready_out,
  input wire logic host_rd_in,
  input wire logic status_rd_in,
  input wire logic fifo_en_in,
  input wire logic [1:0] trig_sel_in,
  input wire logic [1:0] word_len_in,
  input wire logic enh_en_in,
  input wire logic auto_rts_en_in,
  input wire logic auto_cts_en_in,
  input wire logic rts_req_in,
  input wire logic rts_int_en_in,
  input wire logic cts_int_en_in,
  input wire logic xoff_int_en_in,
  input wire logic special_en_in,
  input wire logic sw_rx_en_in,
  input wire logic dbl_char_in,
  input wire logic auto_xoff_tx_en_in,
  input wire logic char_wr_in,
  input wire logic [1:0] char_sel_in,
  input wire logic [urxfc_pkg::DATA_W-1:0] char_data_in,
  input wire logic char_tick_in,
  input wire logic cts_n_in,
  output logic [urxfc_pkg::DATA_W-1:0] hold_data_out,
  output logic [urxfc_pkg::ERR_W-1:0] err_tags_out,
  output logic data_ready_out,
  output logic [urxfc_pkg::CNT_W-1:0] fill_out,
  output logic rts_n_out,
  output logic tx_enable_out,
  output logic flow_stat_out,
  output logic xoff_stat_out,
  output logic rx_trig_out,
  output logic int_out,
  output logic send_xoff_out,
  output logic send_xon_out
);
  import urxfc_pkg::*;

  typedef struct packed {
    logic [FIFO_DEPTH-1:0][ENTRY_W-1:0] mem;
    logic [PTR_W-1:0] wr;
    logic [PTR_W-1:0] rd;
    logic [CNT_W-1:0] cnt;
    logic [ENTRY_W-1:0] head;
    logic ready;
    logic rts_n;
    logic cts_prev;
    logic tx_en;
    logic xoff_hold;
    logic isr5;
    logic isr4;
    logic trig;
    logic intr;
    logic [3:0][DATA_W-1:0] chars;
    urxfc_pair_t pair;
    logic xoff_pend;
    logic [1:0] ticks;
    logic xoff_sent;
    logic send_xoff;
    logic send_xon;
  } urxfc_state_t;

  urxfc_state_t s_q;
  urxfc_state_t s_d;
  logic b_valid;
  logic [ENTRY_W-1:0] b_data;
  logic b_ready;

  generate
    if (DEPTH != FIFO_DEPTH)
    begin : g_bad_depth
      $error("Only a 16-entry receive FIFO is supported.");
    end
  endgenerate

  urxfc_buf #(
    .W(ENTRY_W)
  ) u_buf (
    .clk_in(clk_in),
    .rstn_in(rstn_in),
    .ce_in(ce_in),
    .in_valid_in(rx_valid_in),
    .in_data_in({rx_err_in, rx_data_in}),
    .in_ready_out(),
    .out_valid_out(b_valid),
    .out_data_out(b_data),
    .out_ready_in(b_ready)
  );

  // The buffer accepts while it has room; the registered copy below mirrors that state.
  logic [1:0] bcnt_q;
  always_ff @(posedge clk_in)
  begin
    if (!rstn_in)
    begin
      bcnt_q <= 2'h0;
    end
    else if (ce_in)
    begin
      bcnt_q <= bcnt_q + {1'b0, rx_valid_in && (bcnt_q != 2'h2)} - {1'b0, b_valid && b_ready};
    end
  end

  // A full FIFO stalls the buffer instead of overwriting, so the receiver loses nothing.
  assign b_ready = (s_q.cnt < (fifo_en_in ? CNT_FULL : CNT_ONE));

  always_comb
  begin
    logic [DATA_W-1:0] mask;
    logic [DATA_W-1:0] cur;
    logic pop;
    logic take;
    logic consume;
    logic special;
    logic xoff_hit;
    logic xon_hit;
    logic rdp;
    logic [CNT_W-1:0] hi;
    logic [CNT_W-1:0] lo;
    logic [CNT_W-1:0] lvl;
    s_d = s_q;
    s_d.send_xoff = 1'b0;
    s_d.send_xon = 1'b0;
    mask = WORD_MASK[word_len_in];
    cur = b_data[DATA_W-1:0] & mask;
    pop = b_valid && b_ready;
    consume = 1'b0;
    xoff_hit = 1'b0;
    xon_hit = 1'b0;
    special = special_en_in && (cur == (s_q.chars[SEL_XOFF2] & mask));
    hi = TRIG_HI[trig_sel_in];
    lo = TRIG_LO[trig_sel_in];
    lvl = TRIG_LVL[trig_sel_in];
    if (char_wr_in)
    begin
      s_d.chars[char_sel_in] = char_data_in;
    end
    if (pop && sw_rx_en_in)
    begin
      if (!dbl_char_in)
      begin
        xoff_hit = (cur == (s_q.chars[SEL_XOFF1] & mask));
        xon_hit = (cur == (s_q.chars[SEL_XON1] & mask));
      end
      else
      begin
        case (s_q.pair)
          URXFC_PAIR_XON1: xon_hit = (cur == (s_q.chars[SEL_XON2] & mask));
          URXFC_PAIR_XOFF1: xoff_hit = (cur == (s_q.chars[SEL_XOFF2] & mask));
          default: ;
        endcase
        if (cur == (s_q.chars[SEL_XON1] & mask))
        begin
          s_d.pair = URXFC_PAIR_XON1;
        end
        else if (cur == (s_q.chars[SEL_XOFF1] & mask))
        begin
          s_d.pair = URXFC_PAIR_XOFF1;
        end
        else
        begin
          s_d.pair = URXFC_PAIR_IDLE;
        end
        if (xon_hit || xoff_hit)
        begin
          s_d.pair = URXFC_PAIR_IDLE;
        end
      end
      consume = xoff_hit || xon_hit;
    end
    take = pop && (!consume || special);
    rdp = host_rd_in && (s_q.cnt != '0);
    if (take)
    begin
      s_d.mem[s_q.wr] = b_data;
      s_d.wr = s_q.wr + 4'h1;
    end
    if (rdp)
    begin
      s_d.rd = s_q.rd + 4'h1;
    end
    s_d.cnt = s_q.cnt + {4'h0, take} - {4'h0, rdp};
    s_d.head = s_d.mem[s_d.rd];
    // Halting only gates the start of the next character; one in flight always completes.
    if (xoff_hit)
    begin
      s_d.xoff_hold = 1'b1;
    end
    else if (xon_hit)
    begin
      s_d.xoff_hold = 1'b0;
    end
    if (!rts_req_in || !auto_rts_en_in)
    begin
      s_d.rts_n = !rts_req_in;
    end
    else if (!s_q.rts_n && s_d.cnt >= hi)
    begin
      s_d.rts_n = 1'b1;
    end
    else if (s_q.rts_n && s_d.cnt <= lo)
    begin
      s_d.rts_n = 1'b0;
    end
    s_d.cts_prev = cts_n_in;
    s_d.tx_en = !s_d.xoff_hold && !(auto_cts_en_in && cts_n_in);
    if (status_rd_in)
    begin
      s_d.isr5 = 1'b0;
      s_d.isr4 = 1'b0;
    end
    if (xon_hit)
    begin
      s_d.isr4 = 1'b0;
    end
    // Hardware sets come last so an event in the clearing cycle is kept.
    if (enh_en_in && rts_int_en_in && s_d.rts_n && !s_q.rts_n)
    begin
      s_d.isr5 = 1'b1;
    end
    if (enh_en_in && cts_int_en_in && cts_n_in && !s_q.cts_prev)
    begin
      s_d.isr5 = 1'b1;
    end
    if ((xoff_hit && xoff_int_en_in) || (pop && special))
    begin
      s_d.isr4 = 1'b1;
    end
    s_d.trig = (s_d.cnt >= lvl);
    s_d.intr = s_d.isr5 || s_d.isr4 || s_d.trig;
    if (!auto_xoff_tx_en_in)
    begin
      s_d.xoff_pend = 1'b0;
      s_d.xoff_sent = 1'b0;
      s_d.ticks = 2'h0;
    end
    else if (s_q.xoff_pend)
    begin
      if (char_tick_in)
      begin
        s_d.ticks = s_q.ticks + 2'h1;
        if (s_d.ticks == XOFF_DELAY_CHARS)
        begin
          s_d.send_xoff = 1'b1;
          s_d.xoff_pend = 1'b0;
          s_d.xoff_sent = 1'b1;
        end
      end
    end
    else if (!s_q.xoff_sent && s_d.cnt >= lvl)
    begin
      s_d.xoff_pend = 1'b1;
      s_d.ticks = 2'h0;
    end
    else if (s_q.xoff_sent && s_d.cnt <= lo)
    begin
      s_d.send_xon = 1'b1;
      s_d.xoff_sent = 1'b0;
    end
    s_d.ready = (bcnt_q + {1'b0, rx_valid_in && (bcnt_q != 2'h2)}
      - {1'b0, pop}) != 2'h2;
  end

  always_ff @(posedge clk_in)
  begin
    if (!rstn_in)
    begin
      s_q <= '0;
      s_q.chars <= {4{CHAR_RESET}};
      s_q.pair <= URXFC_PAIR_IDLE;
      s_q.rts_n <= 1'b1;
      s_q.ready <= 1'b1;
      s_q.tx_en <= 1'b1;
    end
    else if (ce_in)
    begin
      s_q <= s_d;
    end
  end

  assign rx_ready_out = s_q.ready;
  assign hold_data_out = s_q.head[DATA_W-1:0];
  assign err_tags_out = s_q.head[ENTRY_W-1:DATA_W];
  assign data_ready_out = (s_q.cnt != '0);
  assign fill_out = s_q.cnt;
  assign rts_n_out = s_q.rts_n;
  assign tx_enable_out = s_q.tx_en;
  assign flow_stat_out = s_q.isr5;
  assign xoff_stat_out = s_q.isr4;
  assign rx_trig_out = s_q.trig;
  assign int_out = s_q.intr;
  assign send_xoff_out = s_q.send_xoff;
  assign send_xon_out = s_q.send_xon;
endmodule // urxfc_top

// ---- test/urxfc_assertions.sv ----
// Concurrent checks on the ports of the receive FIFO and flow-control block.
`timescale 1ns/1ps
module urxfc_assertions #(
  parameter int DEPTH = 16
) (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic ce_in,
  input wire logic host_rd_in,
  input wire logic [1:0] trig_sel_in,
  input wire logic enh_en_in,
  input wire logic auto_rts_en_in,
  input wire logic auto_cts_en_in,
  input wire logic rts_req_in,
  input wire logic cts_int_en_in,
  input wire logic cts_n_in,
  input wire logic data_ready_out,
  input wire logic [urxfc_pkg::CNT_W-1:0] fill_out,
  input wire logic rts_n_out,
  input wire logic tx_enable_out,
  input wire logic flow_stat_out,
  input wire logic rx_trig_out,
  input wire logic send_xoff_out,
  input wire logic send_xon_out
);
  import urxfc_pkg::*;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rstn_in);
  a_fill_bound: assert property (fill_out <= DEPTH)
    else $error("fill above depth");
  a_ready_fill: assert property (data_ready_out == (fill_out != 5'h00))
    else $error("data ready disagrees with fill");
  a_read_pop: assert property (ce_in && host_rd_in && fill_out != 5'h00
    |=> fill_out <= $past(fill_out)) else $error("read did not pop");
  a_rts_manual: assert property (ce_in && !(auto_rts_en_in && rts_req_in)
    |=> rts_n_out == !$past(rts_req_in)) else $error("manual rts wrong");
  a_rts_high: assert property (ce_in && auto_rts_en_in && rts_req_in
    && fill_out >= TRIG_HI[trig_sel_in] |-> ##[0:2] rts_n_out) else $error("rts not dropped");
  a_rts_low: assert property (ce_in && auto_rts_en_in && rts_req_in
    && fill_out <= TRIG_LO[trig_sel_in] |-> ##[0:2] !rts_n_out) else $error("rts not back");
  a_cts_gate: assert property (ce_in && auto_cts_en_in && cts_n_in |=> !tx_enable_out)
    else $error("cts did not gate");
  a_cts_flag: assert property (ce_in && enh_en_in && cts_int_en_in && $rose(cts_n_in)
    |=> flow_stat_out) else $error("cts flag missing");
  a_trig_rise: assert property ($rose(rx_trig_out) |-> fill_out >= TRIG_LVL[trig_sel_in])
    else $error("trigger early");
  a_xoff_pulse: assert property (send_xoff_out |=> !send_xoff_out)
    else $error("xoff request not a pulse");
  c_rts_drop: cover property (auto_rts_en_in && $rose(rts_n_out));
  c_full: cover property (fill_out == DEPTH);
  c_xon: cover property (send_xon_out);
endmodule // urxfc_assertions

bind urxfc_top urxfc_assertions #(.DEPTH(DEPTH)) i_urxfc_assertions (.*);

// ---- test/urxfc_remote.sv ----
// Remote serial device that offers received characters one at a time.
`timescale 1ns/1ps
module urxfc_remote (
  input wire logic clk_in,
  input wire logic ready_in,
  output logic valid_out,
  output logic [7:0] data_out,
  output logic [2:0] err_out
);
  logic [10:0] q[$];
  logic took;
  initial
  begin
    valid_out = 1'b0;
    {err_out, data_out} = 11'h000;
  end
  // An idle line toggles each cycle between its last word and that word's inverse, so stale data never passes as fresh.
  always @(posedge clk_in)
  begin
    took = valid_out && ready_in;
    #1;
    if (took || !valid_out)
    begin
      valid_out = q.size() > 0;
      if (q.size() > 0)
        {err_out, data_out} = q.pop_front();
      else
        {err_out, data_out} = ~{err_out, data_out};
    end
  end
endmodule // urxfc_remote

// ---- test/urxfc_tb_top.sv ----
// Self-checking bench for the receive FIFO and flow-control block.
`timescale 1ns/1ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin fails++; \
  $display("BAD %0t got %h want %h", $time, a, b); end end
module urxfc_tb_top;
  import urxfc_pkg::*;
  logic clk_in = 1'b0;
  logic rstn_in = 1'b0;
  logic ce_in = 1'b1;
  logic rx_valid_in, rx_ready_out, data_ready_out, rts_n_out, tx_enable_out;
  logic flow_stat_out, xoff_stat_out, rx_trig_out, int_out, send_xoff_out, send_xon_out;
  logic [DATA_W-1:0] rx_data_in, hold_data_out, char_data_in;
  logic [ERR_W-1:0] rx_err_in, err_tags_out;
  logic [CNT_W-1:0] fill_out;
  logic [1:0] trig_sel_in, word_len_in, char_sel_in;
  logic host_rd_in, status_rd_in, fifo_en_in, enh_en_in, auto_rts_en_in, auto_cts_en_in;
  logic rts_req_in, rts_int_en_in, cts_int_en_in, xoff_int_en_in, special_en_in;
  logic sw_rx_en_in, dbl_char_in, auto_xoff_tx_en_in, char_wr_in, char_tick_in, cts_n_in;
  int fails, comparisons, cycles, n_xoff, n_xon;
  logic [10:0] exp_q[$];
  always #2.5 clk_in = ~clk_in;
  urxfc_top i_urxfc_top (.*);
  urxfc_remote i_urxfc_remote (.clk_in(clk_in), .ready_in(rx_ready_out),
    .valid_out(rx_valid_in), .data_out(rx_data_in), .err_out(rx_err_in));
  task automatic stop_test();
    if (fails == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // The whole run needs well under ten thousand cycles.
  always @(posedge clk_in)
  begin
    cycles++;
    n_xoff += send_xoff_out;
    n_xon += send_xon_out;
    if (cycles == 30000)
    begin
      fails++;
      stop_test();
    end
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  task automatic put(input logic [7:0] d, input logic [2:0] e, input bit keep);
    i_urxfc_remote.q.push_back({e, d});
    if (keep)
      exp_q.push_back({e, d});
    cyc(5);
  endtask
  task automatic rd();
    logic [10:0] w;
    w = exp_q.pop_front();
    `CHK(hold_data_out, w[7:0])
    `CHK(err_tags_out, w[10:8])
    host_rd_in = 1'b1;
    cyc(1);
    host_rd_in = 1'b0;
    cyc(3);
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    cyc(1);
    s = 1'b0;
    cyc(3);
  endtask
  task automatic wchar(input logic [1:0] s, input logic [7:0] d);
    char_sel_in = s;
    char_data_in = d;
    pulse(char_wr_in);
  endtask
  initial
  begin
    {host_rd_in, status_rd_in, enh_en_in, auto_rts_en_in, auto_cts_en_in, rts_req_in} = '0;
    {rts_int_en_in, cts_int_en_in, xoff_int_en_in, special_en_in, sw_rx_en_in} = '0;
    {dbl_char_in, auto_xoff_tx_en_in, char_wr_in, char_tick_in, cts_n_in} = '0;
    {char_sel_in, char_data_in, trig_sel_in} = '0;
    fifo_en_in = 1'b1;
    word_len_in = 2'h3;
    cyc(4);
    rstn_in = 1'b1;
    cyc(1);
    for (int i = 0; i < 18; i++)
      put(i[7:0], i[2:0], 1);
    `CHK(fill_out, 5'h10)
    `CHK(rx_ready_out, 1'b0)
    `CHK(data_ready_out, 1'b1)
    repeat (18) rd();
    `CHK(data_ready_out, 1'b0)
    fifo_en_in = 1'b0;
    put(8'ha5, 3'h1, 1);
    put(8'h5a, 3'h6, 1);
    `CHK(fill_out, 5'h01)
    rd();
    rd();
    fifo_en_in = 1'b1;
    {enh_en_in, rts_int_en_in, auto_rts_en_in, rts_req_in} = 4'hf;
    for (int t = 0; t < 4; t++)
    begin
      trig_sel_in = t[1:0];
      for (int n = 1; n <= TRIG_HI[t]; n++)
      begin
        put(n[7:0], 3'h0, 1);
        `CHK(rts_n_out, n >= TRIG_HI[t])
        `CHK(rx_trig_out, n >= TRIG_LVL[t])
      end
      `CHK(flow_stat_out, 1'b1)
      pulse(status_rd_in);
      for (int n = TRIG_HI[t]; n > 0; n--)
      begin
        rd();
        `CHK(rts_n_out, n - 1 > TRIG_LO[t])
      end
    end
    {auto_rts_en_in, rts_req_in, sw_rx_en_in, xoff_int_en_in} = 4'h3;
    put(8'h00, 3'h0, 0);
    `CHK(fill_out, 5'h00)
    wchar(SEL_XON1, 8'h11);
    wchar(SEL_XOFF1, 8'h13);
    wchar(SEL_XON2, 8'h12);
    wchar(SEL_XOFF2, 8'h14);
    pulse(status_rd_in);
    word_len_in = 2'h0;
    put(8'hf3, 3'h0, 0);
    `CHK(tx_enable_out, 1'b0)
    `CHK(xoff_stat_out, 1'b1)
    `CHK(int_out, 1'b1)
    put(8'h11, 3'h0, 0);
    `CHK(tx_enable_out, 1'b1)
    `CHK(xoff_stat_out, 1'b0)
    word_len_in = 2'h3;
    put(8'hf3, 3'h2, 1);
    `CHK(fill_out, 5'h01)
    dbl_char_in = 1'b1;
    put(8'h13, 3'h0, 1);
    `CHK(tx_enable_out, 1'b1)
    put(8'h14, 3'h0, 0);
    `CHK(tx_enable_out, 1'b0)
    put(8'h11, 3'h0, 1);
    put(8'h12, 3'h0, 0);
    `CHK(tx_enable_out, 1'b1)
    `CHK(fill_out, 5'h03)
    repeat (3) rd();
    {dbl_char_in, special_en_in} = 2'h1;
    pulse(status_rd_in);
    put(8'h14, 3'h5, 1);
    `CHK(xoff_stat_out, 1'b1)
    rd();
    {special_en_in, sw_rx_en_in, auto_cts_en_in, cts_int_en_in} = 4'h3;
    pulse(status_rd_in);
    cts_n_in = 1'b1;
    cyc(2);
    `CHK(tx_enable_out, 1'b0)
    `CHK(flow_stat_out, 1'b1)
    cts_n_in = 1'b0;
    cyc(2);
    `CHK(tx_enable_out, 1'b1)
    auto_xoff_tx_en_in = 1'b1;
    trig_sel_in = 2'h1;
    n_xoff = 0;
    n_xon = 0;
    repeat (4) put(8'h33, 3'h0, 1);
    pulse(char_tick_in);
    `CHK(n_xoff, 0)
    pulse(char_tick_in);
    `CHK(n_xoff, 1)
    repeat (2) rd();
    `CHK(n_xon, 0)
    rd();
    `CHK(n_xon, 1)
    rd();
    stop_test();
  end
endmodule // urxfc_tb_top
